// ---- inc/sxf_pkg.sv ----
// constants, register map and field layout of the sequencer exit and fault latch block
// Function
// RULE1 - sixty-three state cells, each reachable from any other cell
// RULE2 - every state exits by sequence, monitor fault or timeout to a programmed next
// RULE3 - eight driver outputs are set by the state and held while it is active
// RULE4 - warning raised by converter limit faults or secondary trips on supply inputs
// RULE5 - warning sources are ORed and offered to all three exit detectors; the code feeds it only to the sequence and monitor detectors
// RULE6 - host jump command advances the engine through sequence and timeout detectors
// RULE7 - sequence detector watches one selected input for its programmed level
// RULE8 - sequence qualifying delay programmable from 10 us to 400 ms
// RULE9 - input must hold its level for the whole delay; a change restarts it
// RULE10 - monitor detector is a wide OR of selected inputs deviating from expected
// RULE11 - monitor detector has no delay and exits at once
// RULE12 - next state definition loads in about 20 us before taking effect
// RULE13 - timeout exit taken when its delay expires before sequence is met
// RULE14 - timeout delay programmable from 100 us to 400 ms, independent of sequence
// RULE15 - on entry each driver output takes the level programmed for that state
// RULE16 - fault latch has one sticky bit per input over two registers
// RULE17 - host can read the fault latch to learn which inputs faulted
// RULE18 - latching enabled per state; disabled states keep old bits and record nothing
// RULE19 - status shows live undervoltage, overvoltage and converter limit faults
// RULE20 - status registers are live, never latched
// RULE21 - priority on the same cycle: monitor, then timeout, then sequence
`default_nettype none
package sxf_pkg;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int LOAD_TIME_NS    = 20000;
    localparam int LOAD_CYCLES     = LOAD_TIME_NS / CLK_PERIOD_NS;
    localparam int SEQ_UNIT_NS     = 10000;
    localparam int SEQ_UNIT_CYCLES = SEQ_UNIT_NS / CLK_PERIOD_NS;
    localparam int TO_UNIT_NS      = 100000;
    localparam int TO_UNIT_CYCLES  = TO_UNIT_NS / CLK_PERIOD_NS;
    localparam int NUM_CELLS       = 63;
    localparam int NUM_INPUTS      = 8;
    localparam int CELL_WORDS      = 3;

    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_STATE     = 12'h004;
    localparam logic [11:0] OFF_FLT_LOW   = 12'h008;
    localparam logic [11:0] OFF_FLT_HIGH  = 12'h00c;
    localparam logic [11:0] OFF_STAT_UVOV = 12'h010;
    localparam logic [11:0] OFF_STAT_WARN = 12'h014;
    localparam logic [11:0] OFF_CELL_BASE = 12'h100;
    localparam logic [11:0] OFF_CELL_END  = 12'h4f0;

    localparam int CTRL_JUMP_BIT  = 0;
    localparam int W0_OUT_LSB     = 0;
    localparam int W0_SEL_LSB     = 8;
    localparam int W0_LVL_BIT     = 12;
    localparam int W0_LATCH_BIT   = 13;
    localparam int W0_SEQ_NXT_LSB = 16;
    localparam int W0_MON_NXT_LSB = 24;
    localparam int W1_MASK_LSB    = 0;
    localparam int W1_TO_NXT_LSB  = 16;
    localparam int W2_SEQ_DLY_LSB = 0;
    localparam int W2_TO_DLY_LSB  = 16;
    localparam logic [3:0] SEL_WARN = 4'h8;

    localparam logic [31:0] CELL_RST   = 32'h0000_0000;
    localparam logic [7:0]  LATCH_RST  = 8'h00;
    localparam logic [5:0]  START_CELL = 6'h00;

    typedef enum logic [0:0] {
        ENG_RUN  = 1'b0,
        ENG_LOAD = 1'b1
    } sxf_eng_t;
endpackage : sxf_pkg
`default_nettype wire

// ---- core/sxf_seq_exit.sv ----
// sequencing engine: state cells, exit detectors, fault latch, status and apb slave
`default_nettype none
module sxf_seq_exit (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  supply_ok,
    input  wire logic [7:0]  uv_flag,
    input  wire logic [7:0]  ov_flag,
    input  wire logic [7:0]  adc_limit_fault,
    input  wire logic [3:0]  secondary_trip,
    output logic      [7:0]  drv_out
);
    localparam logic [8:0]  LOAD_LAST = 9'(sxf_pkg::LOAD_CYCLES - 1);
    localparam logic [7:0]  SEQ_LAST  = 8'(sxf_pkg::SEQ_UNIT_CYCLES - 1);
    localparam logic [11:0] TO_LAST   = 12'(sxf_pkg::TO_UNIT_CYCLES - 1);

    // every property runs on pclk and sleeps through reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic [5:0] cell_clamp(input logic [5:0] idx);
        // index 63 is not a cell; it falls back to the start cell
        cell_clamp = (idx == 6'h3f) ? sxf_pkg::START_CELL : idx;
    endfunction : cell_clamp

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [35:0] sync1_ff;
    logic [35:0] sync2_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 36'h0_0000_0000;
            sync2_ff <= 36'h0_0000_0000;
        end else begin
            sync1_ff <= {secondary_trip, adc_limit_fault, ov_flag, uv_flag, supply_ok};
            sync2_ff <= sync1_ff;
        end
    end
    logic [7:0] ok_s;
    logic [7:0] uv_s;
    logic [7:0] ov_s;
    logic [7:0] adc_s;
    logic [3:0] sec_s;
    logic       warn;
    assign {sec_s, adc_s, ov_s, uv_s, ok_s} = sync2_ff;
    assign warn = (|adc_s) | (|sec_s);                               // RULE4 RULE5

    ////////////////////////////////////////////////////////////////////////////////
    // state cell memory and apb slave
    logic [31:0] cell_mem_ff [0:sxf_pkg::NUM_CELLS-1][0:sxf_pkg::CELL_WORDS-1];
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic        in_cells;
    logic [5:0]  acc_cell;
    logic [1:0]  acc_word;
    logic [11:0] cell_off;
    logic        wr_commit;
    assign cell_off  = paddr - sxf_pkg::OFF_CELL_BASE;
    assign acc_cell  = cell_off[9:4];
    assign acc_word  = paddr[3:2];
    assign in_cells  = (paddr >= sxf_pkg::OFF_CELL_BASE) && (paddr < sxf_pkg::OFF_CELL_END);
    assign wr_commit = psel && penable && pready_ff && pwrite && !pslverr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < sxf_pkg::NUM_CELLS; c++) begin
                for (int w = 0; w < sxf_pkg::CELL_WORDS; w++) begin
                    cell_mem_ff[c][w] <= sxf_pkg::CELL_RST;
                end
            end
        end else if (wr_commit && in_cells && acc_word != 2'h3) begin
            cell_mem_ff[acc_cell][acc_word] <= pwdata;                   // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // engine state
    sxf_pkg::sxf_eng_t eng_ff, nxt_eng;
    logic [5:0]  cur_ff, nxt_cur;
    logic [8:0]  load_cnt_ff, nxt_load_cnt;
    logic [31:0] w0_ff, nxt_w0;
    logic [31:0] w1_ff, nxt_w1;
    logic [31:0] w2_ff, nxt_w2;
    logic [7:0]  drv_ff, nxt_drv;
    logic [7:0]  seq_pre_ff, nxt_seq_pre;
    logic [15:0] seq_cnt_ff, nxt_seq_cnt;
    logic [11:0] to_pre_ff, nxt_to_pre;
    logic [15:0] to_cnt_ff, nxt_to_cnt;
    logic        jump_ff, nxt_jump;
    logic [7:0]  latch_ff, nxt_latch;

    logic [3:0]  sel;
    logic [8:0]  mon_mask;
    logic [15:0] seq_dly;
    logic [15:0] to_dly;
    logic        sel_sig;
    logic        seq_cond;
    logic        seq_met;
    logic        to_met;
    logic        mon_hit;
    logic        seq_exit;
    logic        to_exit;
    logic        run;
    logic        jump_wr;
    logic        take;
    logic [5:0]  target;
    logic [7:0]  clr_lat;

    assign sel      = w0_ff[sxf_pkg::W0_SEL_LSB +: 4];
    assign mon_mask = w1_ff[sxf_pkg::W1_MASK_LSB +: 9];
    assign seq_dly  = w2_ff[sxf_pkg::W2_SEQ_DLY_LSB +: 16];
    assign to_dly   = w2_ff[sxf_pkg::W2_TO_DLY_LSB +: 16];
    assign run      = (eng_ff == sxf_pkg::ENG_RUN);
    assign sel_sig  = (sel == sxf_pkg::SEL_WARN) ? warn :                          // RULE5 RULE7
                      ((sel < sxf_pkg::SEL_WARN) ? ok_s[sel[2:0]] : 1'b0);
    assign seq_cond = (sel_sig == w0_ff[sxf_pkg::W0_LVL_BIT]);                     // RULE7
    assign seq_met  = seq_cond && (seq_cnt_ff >= seq_dly);                         // RULE8 RULE9
    assign to_met   = (to_dly != 16'h0000) && (to_cnt_ff >= to_dly);               // RULE13 RULE14
    // monitor sees faults as not-okay inputs plus the warning, no filter
    assign mon_hit  = |(mon_mask & {warn, ~ok_s}); // RULE10 RULE11 RULE5
    assign seq_exit = seq_met || jump_ff;                                          // RULE6
    assign to_exit  = to_met || (jump_ff && to_dly != 16'h0000);                   // RULE6
    assign take     = run && (mon_hit || to_exit || seq_exit);                     // RULE2
    assign jump_wr  = wr_commit && paddr == sxf_pkg::OFF_CTRL && pwdata[sxf_pkg::CTRL_JUMP_BIT];
    assign clr_lat  = {wr_commit && paddr == sxf_pkg::OFF_FLT_HIGH ? pwdata[3:0] : 4'h0,
                       wr_commit && paddr == sxf_pkg::OFF_FLT_LOW ? pwdata[3:0] : 4'h0};

    always_comb begin
        if (mon_hit) begin
            target = w0_ff[sxf_pkg::W0_MON_NXT_LSB +: 6];                          // RULE21
        end else if (to_exit) begin
            target = w1_ff[sxf_pkg::W1_TO_NXT_LSB +: 6];                           // RULE21
        end else begin
            target = w0_ff[sxf_pkg::W0_SEQ_NXT_LSB +: 6];
        end
    end

    always_comb begin
        nxt_eng      = eng_ff;
        nxt_cur      = cur_ff;
        nxt_load_cnt = load_cnt_ff;
        nxt_w0       = w0_ff;
        nxt_w1       = w1_ff;
        nxt_w2       = w2_ff;
        nxt_drv      = drv_ff;
        nxt_seq_pre  = 8'h00;
        nxt_seq_cnt  = 16'h0000;
        nxt_to_pre   = 12'h000;
        nxt_to_cnt   = 16'h0000;
        // a jump written during a load waits for the next state; set wins over consume
        nxt_jump     = jump_wr || (jump_ff && !take);                             // RULE6
        case (eng_ff)
            sxf_pkg::ENG_RUN: begin
                if (take) begin
                    nxt_eng      = sxf_pkg::ENG_LOAD;
                    nxt_cur      = cell_clamp(target);                            // RULE1
                    nxt_load_cnt = 9'h000;
                end else begin
                    // any level change clears the qualifying timer
                    if (seq_cond && seq_cnt_ff < seq_dly) begin                   // RULE9
                        nxt_seq_pre = (seq_pre_ff == SEQ_LAST) ? 8'h00 : seq_pre_ff + 8'h01;
                        nxt_seq_cnt = (seq_pre_ff == SEQ_LAST) ? seq_cnt_ff + 16'h0001
                                                               : seq_cnt_ff;
                    end else if (seq_cond) begin
                        nxt_seq_cnt = seq_cnt_ff;
                    end
                    if (to_cnt_ff < to_dly) begin                                 // RULE14
                        nxt_to_pre = (to_pre_ff == TO_LAST) ? 12'h000 : to_pre_ff + 12'h001;
                        nxt_to_cnt = (to_pre_ff == TO_LAST) ? to_cnt_ff + 16'h0001 : to_cnt_ff;
                    end else begin
                        nxt_to_cnt = to_cnt_ff;
                    end
                end
            end
            sxf_pkg::ENG_LOAD: begin
                if (load_cnt_ff == LOAD_LAST) begin                               // RULE12
                    nxt_eng = sxf_pkg::ENG_RUN;
                    nxt_w0  = cell_mem_ff[cur_ff][0];
                    nxt_w1  = cell_mem_ff[cur_ff][1];
                    nxt_w2  = cell_mem_ff[cur_ff][2];
                    nxt_drv = cell_mem_ff[cur_ff][0][sxf_pkg::W0_OUT_LSB +: 8];   // RULE15 RULE3
                end else begin
                    nxt_load_cnt = load_cnt_ff + 9'h001;
                end
            end
            default: begin
                nxt_eng = sxf_pkg::ENG_LOAD;
            end
        endcase
        // old bits kept; set wins over a software clear in the same cycle
        nxt_latch = latch_ff & ~clr_lat;
        if (w0_ff[sxf_pkg::W0_LATCH_BIT]) begin                                   // RULE18
            nxt_latch = nxt_latch | ~ok_s;                                        // RULE16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_ff      <= sxf_pkg::ENG_LOAD;
            cur_ff      <= sxf_pkg::START_CELL;
            load_cnt_ff <= 9'h000;
            w0_ff       <= sxf_pkg::CELL_RST;
            w1_ff       <= sxf_pkg::CELL_RST;
            w2_ff       <= sxf_pkg::CELL_RST;
            drv_ff      <= 8'h00;
            seq_pre_ff  <= 8'h00;
            seq_cnt_ff  <= 16'h0000;
            to_pre_ff   <= 12'h000;
            to_cnt_ff   <= 16'h0000;
            jump_ff     <= 1'b0;
            latch_ff    <= sxf_pkg::LATCH_RST;
        end else begin
            eng_ff      <= nxt_eng;
            cur_ff      <= nxt_cur;
            load_cnt_ff <= nxt_load_cnt;
            w0_ff       <= nxt_w0;
            w1_ff       <= nxt_w1;
            w2_ff       <= nxt_w2;
            drv_ff      <= nxt_drv;
            seq_pre_ff  <= nxt_seq_pre;
            seq_cnt_ff  <= nxt_seq_cnt;
            to_pre_ff   <= nxt_to_pre;
            to_cnt_ff   <= nxt_to_cnt;
            jump_ff     <= nxt_jump;
            latch_ff    <= nxt_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb read path: no wait state, data captured in the setup cycle
    always_comb begin
        nxt_pready  = psel && !penable;
        nxt_pslverr = 1'b0;
        nxt_prdata  = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                sxf_pkg::OFF_CTRL:      nxt_prdata = {31'h0000_0000, jump_ff};
                sxf_pkg::OFF_STATE:     nxt_prdata = {24'h00_0000, eng_ff, 1'b0, cur_ff};
                sxf_pkg::OFF_FLT_LOW:   nxt_prdata = {28'h000_0000, latch_ff[3:0]};   // RULE17
                sxf_pkg::OFF_FLT_HIGH:  nxt_prdata = {28'h000_0000, latch_ff[7:4]};   // RULE17
                sxf_pkg::OFF_STAT_UVOV: nxt_prdata = {16'h0000, ov_s, uv_s}; // RULE19 RULE20
                sxf_pkg::OFF_STAT_WARN: nxt_prdata = {19'h0_0000, warn, sec_s, adc_s}; // RULE19
                default: begin
                    if (in_cells) begin
                        nxt_prdata = (acc_word == 2'h3) ? 32'h0000_0000 :
                                     cell_mem_ff[acc_cell][acc_word];
                    end else begin
                        nxt_pslverr = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign drv_out = drv_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    load_enter_a: assert property (take |=> eng_ff == sxf_pkg::ENG_LOAD // RULE2
        && load_cnt_ff == 9'h000 && cur_ff == cell_clamp($past(target)))
        else $error("exit did not start a load");
    load_done_a: assert property (eng_ff == sxf_pkg::ENG_LOAD // RULE12
        && load_cnt_ff == LOAD_LAST |=> run && drv_ff == $past(cell_mem_ff[cur_ff][0][7:0]))
        else $error("load end wrong");
    drv_hold_a: assert property (run && $past(run) |-> $stable(drv_ff)) // RULE3
        else $error("outputs changed inside a state");
    mon_prio_a: assert property (run && mon_hit // RULE21
        |=> cur_ff == cell_clamp($past(w0_ff[29:24])))
        else $error("monitor exit not first");
    to_prio_a: assert property (run && !mon_hit && to_met // RULE13
        |=> cur_ff == cell_clamp($past(w1_ff[21:16])))
        else $error("timeout exit not before sequence");
    seq_qual_a: assert property (run && !mon_hit && !to_exit && !jump_ff // RULE9
        && seq_dly != 16'h0000 && seq_met |-> $past(seq_cond))
        else $error("sequence exit without qualifying");
    seq_restart_a: assert property (run && !seq_cond // RULE9
        |=> seq_pre_ff == 8'h00 && seq_cnt_ff == 16'h0000)
        else $error("qualifying timer not restarted");
    latch_keep_a: assert property (clr_lat == 8'h00 // RULE16
        |=> (latch_ff & $past(latch_ff)) == $past(latch_ff))
        else $error("latched fault lost");
    latch_clr_a: assert property (!w0_ff[13] && clr_lat != 8'h00 // RULE16
        |=> (latch_ff & $past(clr_lat)) == 8'h00)
        else $error("fault latch bit not cleared");
    latch_off_a: assert property (!w0_ff[13] && clr_lat == 8'h00 |=> $stable(latch_ff)) // RULE18
        else $error("latch recorded while disabled");
    jump_go_a: assert property (run && jump_ff |=> eng_ff == sxf_pkg::ENG_LOAD) // RULE6
        else $error("jump not taken");
    mon_fast_a: assert property (run && mon_hit |=> eng_ff == sxf_pkg::ENG_LOAD) // RULE11
        else $error("monitor exit delayed");
    stat_live_a: assert property (psel && !penable && paddr == sxf_pkg::OFF_STAT_UVOV // RULE20
        |=> prdata_ff[15:0] == {$past(ov_s), $past(uv_s)})
        else $error("status not live");

    mon_exit_c: cover property (run && mon_hit);
    latch_clr_c: cover property (wr_commit && clr_lat != 8'h00);
    to_exit_c: cover property (run && !mon_hit && to_met);
    seq_dly_c: cover property (run && seq_met && seq_dly != 16'h0000);
    jump_c: cover property (run && jump_ff && !mon_hit);
endmodule : sxf_seq_exit
`default_nettype wire

// ---- test/sxf_supply_model.sv ----
// supervised supply, monitor flag and warning source model for the sequencer bench
`default_nettype none
module sxf_supply_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] set_ok,
    input  wire logic [7:0] set_uv,
    input  wire logic [7:0] set_ov,
    input  wire logic [7:0] set_adc,
    input  wire logic [3:0] set_trip,
    output logic      [7:0] supply_ok,
    output logic      [7:0] uv_flag,
    output logic      [7:0] ov_flag,
    output logic      [7:0] adc_limit_fault,
    output logic      [3:0] secondary_trip
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////////////
    // detector levels move only after an edge; a board in reset shows every supply okay
    // except input 0, which is the start trigger of the sequence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_ok       <= 8'hfe;
            uv_flag         <= 8'h00;
            ov_flag         <= 8'h00;
            adc_limit_fault <= 8'h00;
            secondary_trip  <= 4'h0;
        end else begin
            supply_ok       <= set_ok;
            uv_flag         <= set_uv;
            ov_flag         <= set_ov;
            adc_limit_fault <= set_adc;
            secondary_trip  <= set_trip;
        end
    end
endmodule : sxf_supply_model
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the sequencer exit and fault latch block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  supply_ok, uv_flag, ov_flag, adc_limit_fault, drv_out;
    logic [7:0]  set_ok, set_uv, set_ov, set_adc;
    logic [3:0]  secondary_trip, set_trip;
    int          error_cnt, checks_done, cycles, n;
    // cells 0..3, words 0..2: start, run with monitor and timeout, warning gate, parked
    localparam logic [31:0] CELLS [12] = '{32'h0001_1001, 32'h0000_0000, 32'h0000_0001,
        32'h0200_3f02, 32'h0003_0002, 32'h0001_0000, 32'h0001_1804, 32'h0000_0000,
        32'h0000_0000, 32'h0000_1f08, 32'h0000_0000, 32'h0000_0000};

    sxf_seq_exit sxf_seq_exit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok), .uv_flag(uv_flag),
        .ov_flag(ov_flag), .adc_limit_fault(adc_limit_fault),
        .secondary_trip(secondary_trip), .drv_out(drv_out));

    sxf_supply_model sxf_supply_model_inst (.pclk(pclk), .presetn(presetn), .set_ok(set_ok),
        .set_uv(set_uv), .set_ov(set_ov), .set_adc(set_adc), .set_trip(set_trip),
        .supply_ok(supply_ok), .uv_flag(uv_flag), .ov_flag(ov_flag),
        .adc_limit_fault(adc_limit_fault), .secondary_trip(secondary_trip));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // whole run is near 6000 cycles; a hung handshake or wait ends here
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
        return {31'h0, (v >= lo && v <= hi)};
    endfunction : in_rng

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_drv(input logic [7:0] v);
        n = 0;
        while (drv_out !== v && n < 4000) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : wait_drv

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {set_uv, set_ov, set_adc, set_trip} = '0;
        set_ok = 8'hfe;
        {error_cnt, checks_done, cycles} = '0;
        repeat (6) @(posedge pclk);
        check("drv in reset", {24'h0, drv_out}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        check("state loading", rd, 32'h0000_0080);
        for (int i = 0; i < 12; i++)
            apb(1'b1, 12'h100 + 12'(16 * (i / 3) + 4 * (i % 3)), CELLS[i]);
        wait_drv(8'h01);
        check("drv cell0", {24'h0, drv_out}, 32'h01);
        // a short drop inside the qualifying delay must restart it
        @(posedge pclk) set_ok <= 8'hff;
        repeat (200) @(posedge pclk);
        set_ok <= 8'hfe;
        repeat (5) @(posedge pclk);
        set_ok <= 8'hff;
        repeat (700) @(posedge pclk);
        #1 check("drv held", {24'h0, drv_out}, 32'h01);
        wait_drv(8'h02);
        check("sequence exit", in_rng(n, 40, 70), 32'h1);
        @(posedge pclk) set_ok <= 8'hfd;
        wait_drv(8'h04);
        check("monitor exit", in_rng(n, 500, 510), 32'h1);
        @(posedge pclk) set_ok <= 8'hff;
        apb(1'b0, 12'h008, 32'h0);
        check("latch low", rd, 32'h2);
        // cell 2 records nothing
        set_ok <= 8'hdb;
        repeat (10) @(posedge pclk);
        set_ok <= 8'hff;
        set_uv <= 8'ha5;
        set_ov <= 8'h3c;
        repeat (5) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        check("latch low kept", rd, 32'h2);
        apb(1'b0, 12'h00c, 32'h0);
        check("latch high", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check("uv ov status", rd, 32'h3ca5);
        set_uv <= 8'h00;
        repeat (5) @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0);
        check("status live", rd, 32'h3c00);
        set_adc  <= 8'h81;
        set_trip <= 4'h4;
        repeat (5) @(posedge pclk);
        apb(1'b0, 12'h014, 32'h0);
        check("warn status", rd, 32'h1481);
        set_adc  <= 8'h00;
        set_trip <= 4'h0;
        wait_drv(8'h02);
        check("warning exit", {24'h0, drv_out}, 32'h02);
        wait_drv(8'h08);
        check("timeout exit", in_rng(n, 2995, 3010), 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        wait_drv(8'h01);
        check("jump exit", in_rng(n, 495, 510), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check("state cell0", rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check("latch sticky", rd, 32'h2);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b0, 12'h008, 32'h0);
        check("latch cleared", rd, 32'h0);
        // a second reset in mid-run parks the outputs and restarts the load
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("drv mid reset", {24'h0, drv_out}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        check("state reloading", rd, 32'h0000_0080);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
